// *** common/motion_pkg.sv ***
// Purpose: Shared constants and carriers for the positioning mode control block
// Assumes: 32-bit APB register bus, one word per register
// Notes:   Offsets are byte addresses

package motion_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_POSITION = 8'h10;
   localparam logic [7:0] OFS_TGT_INDEX = 8'h14;
   localparam logic [7:0] OFS_TGT_DATA = 8'h18;

   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_INC = 2'h0;
   localparam logic [1:0] MODE_REF = 2'h1;
   localparam logic [1:0] MODE_JOG = 2'h2;
   localparam logic [1:0] MODE_RESET = MODE_INC;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CMD_START = 0;
   localparam int CMD_NEG = 1;
   localparam int CMD_POS = 2;
   localparam int CMD_STOP = 3;
   localparam int CMD_ACK = 4;
   localparam int CMD_W = 5;
   localparam int CFG_DRV = 0;
   localparam int CFG_REL = 1;
   localparam int CFG_JOGP = 2;
   localparam int CFG_JOGN = 3;
   localparam int CFG_TGT = 8;
   localparam int ST_ERR = 0;
   localparam int ST_INC = 1;
   localparam int ST_REFM = 2;
   localparam int ST_JOGM = 3;
   localparam int ST_RUN = 4;
   localparam int ST_REACHED = 5;
   localparam int ST_DONE = 6;

   // ----------------------------------------------------------------
   // Target numbers and table
   // ----------------------------------------------------------------
   localparam logic [7:0] TGT_MIN = 8'h01;
   localparam logic [7:0] TGT_MAX = 8'h64;
   localparam logic [7:0] TGT_SPEC_A = 8'hFE;
   localparam logic [7:0] TGT_SPEC_B = 8'hFF;
   localparam logic [7:0] TGT_RESET = 8'h01;
   localparam int TABLE_DEPTH = 128;
   localparam logic [6:0] SLOT_SPEC_A = 7'h7E;
   localparam logic [6:0] SLOT_SPEC_B = 7'h7F;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int STEP_PERIOD_NS = 1000;
   localparam int STEP_CYCLES = STEP_PERIOD_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] target;
      logic jog_neg;
      logic jog_pos;
      logic relative_absolute_select;
      logic drive_en;
   } cfg_t;

   typedef struct packed {
      logic start;
      logic seek;
      logic jog;
      logic dir_pos;
      logic signed [31:0] goal;
   } axis_cmd_t;

   typedef struct packed {
      logic busy;
      logic arrived;
      logic signed [31:0] position;
   } axis_stat_t;

endpackage

// *** verilog/axis_drive.sv ***
// Purpose: Step generator and position counter for one axis
// Assumes: ref_hit already synchronised to mclk
// Notes:   arrived is a one-cycle pulse

`timescale 1ns/100ps
`default_nettype none

module axis_drive #(
   parameter int STEP_DIV = motion_pkg::STEP_CYCLES
) (
   input wire logic mclk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire motion_pkg::axis_cmd_t cmd, // Motion request
   input wire logic abort, // End current motion
   input wire logic ref_hit, // Reference switch level
   input wire logic [1:0] jog_hold, // Jog levels {neg,pos}
   output motion_pkg::axis_stat_t stat, // Motion state
   output logic step_out, // Step pulse
   output logic dir_out // Direction, high positive
);

   logic [15:0] tick_cnt;
   logic tick;
   logic seek;
   logic jog;
   logic signed [31:0] goal;

   assign tick = (tick_cnt == 16'(STEP_DIV - 1));

   always_ff @(posedge mclk) begin
      if (!rstn || tick || !stat.busy) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         stat <= '0;
         seek <= 1'b0;
         jog <= 1'b0;
         goal <= 32'sh0;
         dir_out <= 1'b1;
         step_out <= 1'b0;
      end else begin
         stat.arrived <= 1'b0;
         step_out <= 1'b0;
         if (abort) begin
            stat.busy <= 1'b0;
         end else if (cmd.start) begin
            stat.busy <= 1'b1;
            seek <= cmd.seek;
            jog <= cmd.jog;
            goal <= cmd.goal;
            dir_out <= cmd.dir_pos;
         end else if (stat.busy && jog && !(dir_out ? jog_hold[0] : jog_hold[1])) begin
            stat.busy <= 1'b0;
         end else if (stat.busy && tick) begin
            if (seek && ref_hit) begin
               stat.position <= 32'sh0;
               stat.busy <= 1'b0;
               stat.arrived <= 1'b1;
            end else if (!seek && !jog && stat.position == goal) begin
               stat.busy <= 1'b0;
               stat.arrived <= 1'b1;
            end else begin
               if (!seek && !jog) begin
                  dir_out <= goal > stat.position;
               end
               step_out <= 1'b1;
               if ((!seek && !jog) ? goal > stat.position : dir_out) begin
                  stat.position <= stat.position + 32'sh1;
               end else begin
                  stat.position <= stat.position - 32'sh1;
               end
            end
         end
      end
   end

   AST_JOG_RELEASE: assert property (@(posedge mclk) disable iff (!rstn)
      stat.busy && jog && jog_hold == 2'b00 && !cmd.start |=> !stat.busy)
      else $error("Jog kept moving after release");

endmodule // axis_drive

`default_nettype wire

// *** verilog/positioning_mode_control.sv ***
// Purpose: Mode control for one positioning channel behind an APB slave
// Assumes: Software issues commands by writing the command register
// Notes:   One command register write is one invocation
//
// Overview of operation
// - Plain start: module picks direction in absolute mode, else moves positive
// - Negative start moves in negative direction in relative and reference modes
// - Positive start moves in positive direction in relative and reference modes
// - Stop ends the active mode, except jog, which restarts next cycle while its request is held
// - Impossible or faulty control raises error
// - Error pending blocks starts and resumes
// - Start request bits clear once accepted
// - Incremental request sets incremental active flag
// - Incremental command selects mode regardless
// - Each invocation snapshots actual position
// - Completion result set to one afterwards
// - Incremental mode approaches predefined targets
// - Reference seek synchronises axis position
// - Jog moves only while request held
// - Target number 1-100, 254, 255 only
// - Reached set at target, cleared on incremental start

`timescale 1ns/100ps
`default_nettype none

module positioning_mode_control #(
   parameter int STEP_DIV = motion_pkg::STEP_CYCLES
) (
   input wire logic mclk, // System clock, 20 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic ref_switch, // Reference switch pin
   output logic step_pulse, // Motor step pin
   output logic step_dir, // Motor direction pin
   output logic drive_enable_out // Drive enable pin
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum {ST_WAIT, ST_EXEC, ST_REPORT} inv_state_t;
   inv_state_t state;
   motion_pkg::cfg_t cfg;
   motion_pkg::axis_cmd_t axis_cmd;
   motion_pkg::axis_stat_t axis_stat;
   logic [1:0] mode, jog_levels;
   logic [motion_pkg::CMD_W-1:0] cmd_pend, next_cmd_pend;
   logic operating_error_flag, position_reached_flag, binary_completion_result;
   logic incremental_active_flag, ref_meta, ref_sync;
   logic signed [31:0] snap_pos, dim;
   logic [6:0] tgt_index;
   logic signed [31:0] dim_table [0:motion_pkg::TABLE_DEPTH-1];
   logic access, addr_ok, wr_en, wr_mode, wr_cmd, mode_ok;
   logic abort, err_set, clr_reached, sel_neg;
   logic [2:0] starts;
   logic [31:0] rd_data, status_word;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic valid_target(input logic [7:0] tn);
      valid_target = (tn >= motion_pkg::TGT_MIN && tn <= motion_pkg::TGT_MAX) ||
         tn == motion_pkg::TGT_SPEC_A || tn == motion_pkg::TGT_SPEC_B;
   endfunction

   function automatic logic [6:0] target_slot(input logic [7:0] tn);
      if (tn == motion_pkg::TGT_SPEC_A) begin
         target_slot = motion_pkg::SLOT_SPEC_A;
      end else if (tn == motion_pkg::TGT_SPEC_B) begin
         target_slot = motion_pkg::SLOT_SPEC_B;
      end else begin
         target_slot = tn[6:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign access = psel && penable;
   assign addr_ok = paddr == motion_pkg::OFS_MODE || paddr == motion_pkg::OFS_CONFIG ||
      paddr == motion_pkg::OFS_COMMAND || paddr == motion_pkg::OFS_STATUS ||
      paddr == motion_pkg::OFS_POSITION || paddr == motion_pkg::OFS_TGT_INDEX ||
      paddr == motion_pkg::OFS_TGT_DATA;
   assign wr_en = access && pready && pwrite && addr_ok;
   assign wr_mode = wr_en && paddr == motion_pkg::OFS_MODE;
   assign wr_cmd = wr_en && paddr == motion_pkg::OFS_COMMAND;
   assign mode_ok = pwdata[1:0] == motion_pkg::MODE_INC ||
      (!axis_stat.busy && (pwdata[1:0] == motion_pkg::MODE_REF ||
      pwdata[1:0] == motion_pkg::MODE_JOG));

   assign status_word = {25'h0000000, binary_completion_result, position_reached_flag,
      axis_stat.busy, mode == motion_pkg::MODE_JOG, mode == motion_pkg::MODE_REF,
      incremental_active_flag, operating_error_flag};

   always_comb begin
      case (paddr)
         motion_pkg::OFS_MODE: rd_data = {30'h00000000, mode};
         motion_pkg::OFS_CONFIG: rd_data = {16'h0000, cfg.target, 4'h0, cfg.jog_neg,
            cfg.jog_pos, cfg.relative_absolute_select, cfg.drive_en};
         motion_pkg::OFS_COMMAND: rd_data = {27'h0000000, cmd_pend};
         motion_pkg::OFS_STATUS: rd_data = status_word;
         motion_pkg::OFS_POSITION: rd_data = snap_pos;
         motion_pkg::OFS_TGT_INDEX: rd_data = {25'h0000000, tgt_index};
         motion_pkg::OFS_TGT_DATA: rd_data = dim_table[tgt_index];
         default: rd_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access && !pready;
         pslverr <= access && !pready && !addr_ok;
         prdata <= (access && !pready && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg <= '{target: motion_pkg::TGT_RESET, default: 1'b0};
         tgt_index <= 7'h00;
      end else if (wr_en && paddr == motion_pkg::OFS_CONFIG) begin
         cfg.drive_en <= pwdata[motion_pkg::CFG_DRV];
         cfg.relative_absolute_select <= pwdata[motion_pkg::CFG_REL];
         cfg.jog_pos <= pwdata[motion_pkg::CFG_JOGP];
         cfg.jog_neg <= pwdata[motion_pkg::CFG_JOGN];
         cfg.target <= pwdata[motion_pkg::CFG_TGT +: 8];
      end else if (wr_en && paddr == motion_pkg::OFS_TGT_INDEX) begin
         tgt_index <= pwdata[6:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_en && paddr == motion_pkg::OFS_TGT_DATA) begin
         dim_table[tgt_index] <= pwdata;
      end
   end

   // Incremental is always accepted, reference and jog only while idle, code 3 never
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mode <= motion_pkg::MODE_RESET;
         incremental_active_flag <= 1'b1;
      end else if (wr_mode && mode_ok) begin
         mode <= pwdata[1:0];
         incremental_active_flag <= pwdata[1:0] == motion_pkg::MODE_INC;
      end
   end

   // ----------------------------------------------------------------
   // Invocation sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= ST_WAIT;
      end else begin
         case (state)
            ST_WAIT: if (cmd_pend != '0) begin
               state <= ST_EXEC;
            end
            ST_EXEC: state <= ST_REPORT;
            ST_REPORT: state <= ST_WAIT;
            default: state <= ST_WAIT;
         endcase
      end
   end

   // New writes survive the clearing of consumed bits
   always_comb begin
      next_cmd_pend = (state == ST_EXEC) ? '0 : cmd_pend;
      if (wr_cmd) begin
         next_cmd_pend = next_cmd_pend | pwdata[motion_pkg::CMD_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cmd_pend <= '0;
      end else begin
         cmd_pend <= next_cmd_pend;
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   assign starts = cmd_pend[motion_pkg::CMD_POS:motion_pkg::CMD_START];
   assign sel_neg = !starts[0] && starts[1];
   assign dim = dim_table[target_slot(cfg.target)];
   assign jog_levels = (mode == motion_pkg::MODE_JOG) ? {cfg.jog_neg, cfg.jog_pos} : 2'b00;

   always_comb begin
      axis_cmd = '0;
      abort = 1'b0;
      err_set = 1'b0;
      clr_reached = 1'b0;
      if (wr_mode && !mode_ok) begin
         err_set = 1'b1;
      end
      if (wr_mode && pwdata[1:0] == motion_pkg::MODE_INC && axis_stat.busy) begin
         abort = 1'b1;
      end
      if (axis_stat.busy && !cfg.drive_en) begin
         abort = 1'b1;
         err_set = 1'b1;
      end
      if (state == ST_EXEC && cmd_pend[motion_pkg::CMD_STOP]) begin
         abort = 1'b1;
      end else if (state == ST_EXEC && starts != 3'b000) begin
         if (operating_error_flag || !cfg.drive_en || axis_stat.busy ||
            mode == motion_pkg::MODE_JOG) begin
            err_set = 1'b1;
         end else begin
            if ((starts & (starts - 3'b001)) != 3'b000) begin
               err_set = 1'b1;
            end
            if (mode == motion_pkg::MODE_INC) begin
               if (!valid_target(cfg.target)) begin
                  err_set = 1'b1;
               end else begin
                  axis_cmd.start = 1'b1;
                  clr_reached = 1'b1;
                  if (!cfg.relative_absolute_select) begin
                     axis_cmd.goal = dim;
                  end else if (sel_neg) begin
                     axis_cmd.goal = axis_stat.position - dim;
                  end else begin
                     axis_cmd.goal = axis_stat.position + dim;
                  end
                  axis_cmd.dir_pos = !sel_neg;
               end
            end else begin
               axis_cmd.start = 1'b1;
               axis_cmd.seek = 1'b1;
               axis_cmd.dir_pos = !sel_neg;
            end
         end
      end else if (mode == motion_pkg::MODE_JOG && !axis_stat.busy && !abort &&
         jog_levels != 2'b00) begin
         if (jog_levels == 2'b11 || operating_error_flag || !cfg.drive_en) begin
            err_set = 1'b1;
         end else begin
            axis_cmd.start = 1'b1;
            axis_cmd.jog = 1'b1;
            axis_cmd.dir_pos = jog_levels[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         operating_error_flag <= 1'b0;
      end else if (err_set) begin
         operating_error_flag <= 1'b1;
      end else if (state == ST_EXEC && cmd_pend[motion_pkg::CMD_ACK]) begin
         operating_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         position_reached_flag <= 1'b0;
      end else if (axis_stat.arrived && mode == motion_pkg::MODE_INC) begin
         position_reached_flag <= 1'b1;
      end else if (clr_reached) begin
         position_reached_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         binary_completion_result <= 1'b0;
         snap_pos <= 32'sh0;
      end else if (state == ST_REPORT) begin
         binary_completion_result <= 1'b1;
         snap_pos <= axis_stat.position;
      end else if (wr_cmd) begin
         binary_completion_result <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pins and axis
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         drive_enable_out <= 1'b0;
      end else begin
         ref_meta <= ref_switch;
         ref_sync <= ref_meta;
         drive_enable_out <= cfg.drive_en;
      end
   end

   axis_drive #(.STEP_DIV(STEP_DIV)) u_axis (
      .mclk(mclk),
      .rstn(rstn),
      .cmd(axis_cmd),
      .abort(abort),
      .ref_hit(ref_sync),
      .jog_hold(jog_levels),
      .stat(axis_stat),
      .step_out(step_pulse),
      .dir_out(step_dir)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_ERR_BLOCKS_START: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_EXEC && operating_error_flag && starts != 3'b000 |-> !axis_cmd.start)
      else $error("Start taken while error pending");
   AST_START_SELF_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_EXEC && !wr_cmd |=> cmd_pend == '0 ##1 state == ST_WAIT)
      else $error("Request bits not cleared after invocation");
   AST_COMPLETION: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_EXEC |-> ##2 binary_completion_result)
      else $error("Completion result not set");
   AST_INC_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
      wr_mode && pwdata[1:0] == motion_pkg::MODE_INC |=>
      incremental_active_flag && mode == motion_pkg::MODE_INC)
      else $error("Incremental mode not selected");
   AST_MULTI_START: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_EXEC && $countones(starts) > 1 && !cmd_pend[motion_pkg::CMD_STOP]
      |=> operating_error_flag)
      else $error("Multiple starts without error");
   AST_STOP_ENDS: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_EXEC && cmd_pend[motion_pkg::CMD_STOP] |=> !axis_stat.busy)
      else $error("Stop did not end motion");
   AST_TARGET_RANGE: assert property (@(posedge mclk) disable iff (!rstn)
      axis_cmd.start && !axis_cmd.seek && !axis_cmd.jog |-> valid_target(cfg.target))
      else $error("Approach started to invalid target");
   AST_REACHED_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
      clr_reached |=> !position_reached_flag && axis_stat.busy)
      else $error("Reached flag kept on new approach");
   AST_SNAPSHOT: assert property (@(posedge mclk) disable iff (!rstn)
      state == ST_REPORT |=> snap_pos == $past(axis_stat.position))
      else $error("Position snapshot wrong");

endmodule // positioning_mode_control

`default_nettype wire

// *** bench/axis_model.sv ***
// Purpose: Axis mechanics seen by the step and direction pins
// Assumes: One position unit per step pulse
// Notes:   Reference switch closes at REF_AT and beyond
`timescale 1ns/100ps
`default_nettype none
module axis_model #(
   parameter int REF_AT = 8
) (
   input wire logic mclk, // Clock
   input wire logic step_pulse, // Step in
   input wire logic step_dir, // Direction in
   output logic ref_switch // Reference switch
);
   int pos = 0;
   always @(posedge mclk) begin
      if (step_pulse === 1'b1) begin
         pos <= (step_dir === 1'b1) ? pos + 1 : pos - 1;
      end
   end
   assign ref_switch = (pos >= REF_AT);
endmodule // axis_model
`default_nettype wire

// *** bench/positioning_mode_control_tb.sv ***
// Purpose: Self-checking bench for positioning_mode_control
// Assumes: APB master, STEP_DIV of 2
// Notes:   Axis mechanics come from axis_model
`timescale 1ns/100ps
`default_nettype none
module positioning_mode_control_tb;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, bad;
   logic [31:0] pwdata = 32'h0, prdata, rd, dim;
   logic pready, pslverr, err, ref_switch, step_pulse, step_dir, drive_enable_out;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   always #25 mclk = ~mclk;
   positioning_mode_control #(.STEP_DIV(2)) u_positioning_mode_control (.mclk(mclk),
      .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_switch(ref_switch), .step_pulse(step_pulse), .step_dir(step_dir),
      .drive_enable_out(drive_enable_out));
   axis_model u_axis_model (.mclk(mclk), .step_pulse(step_pulse), .step_dir(step_dir),
      .ref_switch(ref_switch));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdst;
      apb(1'b0, motion_pkg::OFS_STATUS, 32'h0);
   endtask
   task automatic cmd(input logic [31:0] d);
      apb(1'b1, motion_pkg::OFS_COMMAND, d);
   endtask
   task automatic wait_idle;
      do rdst; while (rd[motion_pkg::ST_RUN] === 1'b1);
      rdst;
   endtask
   task automatic rdpos(input logic [31:0] exp);
      cmd(32'h8);
      repeat (2) @(posedge mclk);
      apb(1'b0, motion_pkg::OFS_POSITION, 32'h0);
      chk(rd, exp);
   endtask
   function automatic logic [31:0] cfgw(input logic [7:0] t, input logic [3:0] f);
      return {16'h0, t, 4'h0, f};
   endfunction
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(14014));
      dim = 32'd8 + ($urandom % 8);
      bad = 8'd101 + 8'($urandom % 153);
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      rdst;
      chk(rd, 32'h2);
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(8'hFF, 4'h1));
      repeat (2) @(posedge mclk);
      chk(drive_enable_out, 1'b1);
      apb(1'b1, motion_pkg::OFS_MODE, 32'h1);
      cmd(32'h1);
      rdst;
      chk(rd[motion_pkg::ST_REFM], 1'b1);
      chk(step_dir, 1'b1);
      wait_idle;
      rdpos(32'h0);
      $display("test reference done");
      apb(1'b1, motion_pkg::OFS_MODE, 32'h0);
      rdst;
      chk(rd[motion_pkg::ST_INC], 1'b1);
      apb(1'b1, motion_pkg::OFS_TGT_INDEX, 32'h7F);
      apb(1'b1, motion_pkg::OFS_TGT_DATA, dim);
      cmd(32'h4);
      apb(1'b0, motion_pkg::OFS_COMMAND, 32'h0);
      chk(rd, 32'h0);
      rdst;
      chk(rd[6:4], 3'b101);
      wait_idle;
      chk(rd[motion_pkg::ST_REACHED], 1'b1);
      rdpos(dim);
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(8'hFF, 4'h3));
      cmd(32'h2);
      rdst;
      chk(step_dir, 1'b0);
      wait_idle;
      rdpos(32'h0);
      $display("test incremental done");
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(bad, 4'h1));
      cmd(32'h1);
      rdst;
      chk({rd[4], rd[0]}, 2'b01);
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(8'hFF, 4'h3));
      cmd(32'h4);
      rdst;
      chk({rd[4], rd[0]}, 2'b01);
      cmd(32'h10);
      rdst;
      chk(rd[0], 1'b0);
      cmd(32'h7);
      rdst;
      chk({rd[4], rd[0]}, 2'b11);
      cmd(32'h18);
      rdst;
      chk({rd[4], rd[0]}, 2'b00);
      $display("test error done");
      apb(1'b1, motion_pkg::OFS_MODE, 32'h2);
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(8'hFF, 4'h5));
      rdst;
      chk({rd[3], rd[4]}, 2'b11);
      apb(1'b1, motion_pkg::OFS_CONFIG, cfgw(8'hFF, 4'h1));
      rdst;
      chk(rd[4], 1'b0);
      apb(1'b1, motion_pkg::OFS_MODE, 32'h3);
      rdst;
      chk({rd[3], rd[0]}, 2'b11);
      apb(1'b0, 8'hFC, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("test jog and bus done");
      end_sim;
   end
endmodule // positioning_mode_control_tb
`default_nettype wire
